// *** card_cfg_pkg.sv ***
`default_nettype none
package card_cfg_pkg;
  // register map, one byte each
  localparam logic [2:0] ADDR_FORMAT = 3'h0;
  localparam logic [2:0] ADDR_MODE = 3'h1;
  localparam logic [2:0] ADDR_DIVISOR = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  localparam logic [2:0] ADDR_CLEAR = 3'h4;
  localparam logic [2:0] ADDR_ENABLE = 3'h5;
  localparam logic [2:0] ADDR_TXDATA = 3'h6;
  localparam logic [2:0] ADDR_RXDATA = 3'h7;
  // serial_format_config fields
  localparam int GSM_BIT = 7;
  localparam int BLOCK_BIT = 6;
  localparam int PAR_EN_BIT = 5;
  localparam int PAR_ODD_BIT = 4;
  localparam int BCP_LSB = 2;
  localparam int CKS_LSB = 0;
  // card_mode_register fields
  localparam int MODE_SEL_BIT = 0;
  localparam int CLK_STOP_BIT = 1;
  // status / clear / enable layout
  localparam int ST_TX_END = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_PARITY_ERR = 2;
  localparam int ST_OVERRUN = 3;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] DIVISOR_RESET = 8'h00;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  // basic clock cycles per bit
  localparam logic [8:0] S_32 = 9'h020;
  localparam logic [8:0] S_64 = 9'h040;
  localparam logic [8:0] S_372 = 9'h174;
  localparam logic [8:0] S_256 = 9'h100;
  localparam logic [8:0] S_NORMAL = 9'h010;
  // prescaler shift per clock select code
  localparam logic [2:0] PRE_SHIFT_0 = 3'h0;
  localparam logic [2:0] PRE_SHIFT_1 = 3'h2;
  localparam logic [2:0] PRE_SHIFT_2 = 3'h4;
  localparam logic [2:0] PRE_SHIFT_3 = 3'h6;
  // frame positions, in bit times from the start bit
  localparam logic [3:0] ETU_PARITY = 4'h9;
  localparam logic [3:0] ETU_ERRSIG = 4'ha;
  localparam logic [3:0] GSM_END_ETU = 4'hb;
  localparam logic [3:0] STD_END_ETU = 4'hc;
  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_DATA = 2'b01, RX_ERRSIG = 2'b10} rx_state_t;
endpackage
`default_nettype wire

// *** card_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module card_model (
  input wire logic clk,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic par_odd,
  input wire logic bad_par,
  input wire logic [15:0] bit_clks,
  input wire logic txd,
  output logic rxd,
  output logic busy,
  output logic err_seen
);
  logic [11:0] frame;
  initial begin
    rxd = 1'b1;
    busy = 1'b0;
    err_seen = 1'b0;
  end
  ////////////////////////////////////////
  // guard bits are frame bits 10 and 11, which the model drives high on rxd
  always begin
    @(posedge clk);
    if (send) begin
      busy <= 1'b1;
      err_seen <= 1'b0;
      frame = {2'b11, ^send_byte ^ par_odd ^ bad_par, send_byte, 1'b0};
      for (int i = 0; i < 12; i++) begin
        rxd <= frame[i];
        repeat (bit_clks / 2) @(posedge clk);
        if (i == 10) begin
          @(negedge clk);
          err_seen <= ~txd;
        end
        repeat (bit_clks - bit_clks / 2) @(posedge clk);
      end
      busy <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** card_serial.sv ***
// Function
// [R1] card mode select decides whether format bits 7..2 carry card meanings
// [R2] clock select 00 gives undivided clock, 10 gives clock divided by 16
// [R3] gsm timing sets transmit end flag 11.0 bit times after frame start
// [R4] gsm timing also enables the card clock output stop control
// [R5] format bit 6 selects block transfer, else character transfer
// [R6] parity enable appends parity on transmit and checks it on receive
// [R7] software must set parity enable before card mode transfers
// [R8] parity mode bit 4 selects even (0) or odd (1) parity
// [R9] bit cycle code picks 32, 64, 372 or 256 basic cycles per bit
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module card_serial (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rxd,
  output logic txd,
  output logic card_clk,
  output logic irq
);
  import card_cfg_pkg::*;

  logic [7:0] format_reg;
  logic [7:0] mode_reg;
  logic [7:0] divisor_reg;
  logic [3:0] status_reg;
  logic [3:0] enable_reg;
  logic [7:0] rx_data_reg;
  logic card_mode, gsm_mode, block_mode, par_en, par_odd, clk_stop;
  logic [8:0] s_count;
  logic [2:0] pre_shift;
  logic btick;
  logic rx_sync;
  logic [3:0] status_set;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] bit_cycles(input logic card, input logic [1:0] code);
    logic [8:0] s;
    s = S_NORMAL;
    if (card) begin
      case (code)
        2'b00: s = S_32;
        2'b01: s = S_64;
        2'b10: s = S_372;
        2'b11: s = S_256;
        default: s = S_32;
      endcase
    end
    return s;
  endfunction

  function automatic logic [2:0] shift_of(input logic [1:0] code);
    logic [2:0] r;
    case (code)
      2'b00: r = PRE_SHIFT_0;
      2'b01: r = PRE_SHIFT_1;
      2'b10: r = PRE_SHIFT_2;
      2'b11: r = PRE_SHIFT_3;
      default: r = PRE_SHIFT_0;
    endcase
    return r;
  endfunction

  // parity bit that makes the count of ones even, or odd when asked
  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // field decode; card meanings only apply with card mode selected
  assign card_mode = mode_reg[MODE_SEL_BIT];
  assign gsm_mode = card_mode && format_reg[GSM_BIT]; // see [R1]
  assign block_mode = card_mode && format_reg[BLOCK_BIT]; // see [R5]
  assign par_en = format_reg[PAR_EN_BIT]; // see [R6]
  assign par_odd = format_reg[PAR_ODD_BIT]; // see [R8]
  assign clk_stop = gsm_mode && mode_reg[CLK_STOP_BIT]; // see [R4]
  assign s_count = bit_cycles(card_mode, format_reg[BCP_LSB+1:BCP_LSB]); // see [R9]
  assign pre_shift = shift_of(format_reg[CKS_LSB+1:CKS_LSB]); // see [R2]

  tick_divider #(.CNT_W(16)) u_div (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .shift(pre_shift),
    .divisor(divisor_reg),
    .tick(btick)
  );

  in_sync3 #(.RESET_VAL(1'b1)) u_rx_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d(rxd),
    .q(rx_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // card clock: one toggle per basic tick; a stop only holds it low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      card_clk <= 1'b0;
    end else if (ce) begin
      if (!card_mode) begin
        card_clk <= 1'b0;
      end else if (btick && !(clk_stop && !card_clk)) begin // see [R4]
        card_clk <= ~card_clk;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmitter
  tx_state_t tx_state;
  logic [7:0] tx_shift_reg;
  logic [8:0] tx_sub_reg;
  logic [3:0] tx_etu_reg;
  logic tx_etu_end, tx_line, tx_load, tx_done;
  logic [3:0] tx_end_etu;

  assign tx_load = wr && (addr == ADDR_TXDATA) && (tx_state == TX_IDLE);
  assign tx_etu_end = btick && (tx_sub_reg == s_count - 9'h001);
  assign tx_end_etu = gsm_mode ? GSM_END_ETU : STD_END_ETU; // see [R3]
  assign tx_done = (tx_state == TX_SHIFT) && tx_etu_end && (tx_etu_reg + 4'h1 == tx_end_etu);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_sub_reg <= 9'h000;
      tx_etu_reg <= 4'h0;
    end else if (ce) begin
      case (tx_state)
        TX_IDLE: begin
          if (tx_load) begin
            tx_state <= TX_SHIFT;
            tx_shift_reg <= wdata;
            tx_sub_reg <= 9'h000;
            tx_etu_reg <= 4'h0;
          end
        end
        TX_SHIFT: begin
          if (tx_done) begin
            tx_state <= TX_IDLE;
          end else if (tx_etu_end) begin
            tx_sub_reg <= 9'h000;
            tx_etu_reg <= tx_etu_reg + 4'h1;
          end else if (btick) begin
            tx_sub_reg <= tx_sub_reg + 9'h001;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // start, eight data bits lsb first, parity, then idle high
  always_comb begin
    tx_line = 1'b1;
    if (tx_state == TX_SHIFT) begin
      if (tx_etu_reg == 4'h0) begin
        tx_line = 1'b0;
      end else if (tx_etu_reg < ETU_PARITY) begin
        tx_line = tx_shift_reg[3'(tx_etu_reg - 4'h1)];
      end else if (tx_etu_reg == ETU_PARITY && par_en) begin
        tx_line = parity_of(tx_shift_reg, par_odd); // see [R6] see [R8]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  rx_state_t rx_state;
  logic [7:0] rx_shift_reg;
  logic [8:0] rx_sub_reg;
  logic [3:0] rx_etu_reg;
  logic rx_prev_reg, rx_mid, rx_etu_end, rx_start;
  logic rx_last_bit, rx_par_bad, err_drive;

  assign rx_start = rx_prev_reg && !rx_sync;
  assign rx_mid = btick && (rx_sub_reg == {1'b0, s_count[8:1]} - 9'h001);
  assign rx_etu_end = btick && (rx_sub_reg == s_count - 9'h001);
  assign rx_last_bit = par_en ? (rx_etu_reg == ETU_PARITY) : (rx_etu_reg == 4'h8);
  assign rx_par_bad = par_en && (rx_sync != parity_of(rx_shift_reg, par_odd)); // see [R6]
  assign err_drive = (rx_state == RX_ERRSIG) && (rx_etu_reg == ETU_ERRSIG);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_prev_reg <= 1'b1;
    end else if (ce) begin
      rx_prev_reg <= rx_sync;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_shift_reg <= 8'h00;
      rx_sub_reg <= 9'h000;
      rx_etu_reg <= 4'h0;
    end else if (ce) begin
      if (rx_etu_end) begin
        rx_sub_reg <= 9'h000;
        rx_etu_reg <= rx_etu_reg + 4'h1;
      end else if (btick) begin
        rx_sub_reg <= rx_sub_reg + 9'h001;
      end
      case (rx_state)
        RX_IDLE: begin
          if (rx_start) begin
            rx_state <= RX_DATA;
            rx_sub_reg <= 9'h000;
            rx_etu_reg <= 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            if (rx_etu_reg == 4'h0 && rx_sync) begin
              rx_state <= RX_IDLE;
            end else if (rx_etu_reg != 4'h0 && rx_etu_reg < ETU_PARITY) begin
              rx_shift_reg <= {rx_sync, rx_shift_reg[7:1]};
            end
            if (rx_last_bit) begin
              // character transfer answers bad parity with a low error pulse
              rx_state <= (rx_par_bad && card_mode && !block_mode) ? RX_ERRSIG : RX_IDLE; // see [R5]
            end
          end
        end
        RX_ERRSIG: begin
          if (rx_etu_end && rx_etu_reg == ETU_ERRSIG) begin
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txd <= 1'b1;
    end else if (ce) begin
      txd <= tx_line && !err_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events; a set in the cycle of a clear wins
  logic rx_done;
  assign rx_done = (rx_state == RX_DATA) && rx_mid && rx_last_bit;

  always_comb begin
    status_set = 4'h0;
    status_set[ST_TX_END] = tx_done; // see [R3]
    status_set[ST_RX_FULL] = rx_done;
    status_set[ST_PARITY_ERR] = rx_done && rx_par_bad;
    status_set[ST_OVERRUN] = rx_done && status_reg[ST_RX_FULL];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= STATUS_RESET;
    end else if (ce) begin
      if (wr && addr == ADDR_CLEAR) begin
        status_reg <= (status_reg & ~wdata[3:0]) | status_set;
      end else begin
        status_reg <= status_reg | status_set;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_data_reg <= 8'h00;
    end else if (ce && rx_done) begin
      // without parity the last data bit is shifted in on this very edge
      rx_data_reg <= par_en ? rx_shift_reg : {rx_sync, rx_shift_reg[7:1]};
    end
  end

  assign irq = |(status_reg & enable_reg);

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      format_reg <= FORMAT_RESET;
      mode_reg <= MODE_RESET;
      divisor_reg <= DIVISOR_RESET;
      enable_reg <= STATUS_RESET;
    end else if (ce && wr) begin
      case (addr)
        ADDR_FORMAT: format_reg <= wdata;
        ADDR_MODE: mode_reg <= {6'h00, wdata[1:0]};
        ADDR_DIVISOR: divisor_reg <= wdata;
        ADDR_ENABLE: enable_reg <= wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (ce) begin
      rdata <= 8'h00;
      if (rd) begin
        case (addr)
          ADDR_FORMAT: rdata <= format_reg;
          ADDR_MODE: rdata <= mode_reg;
          ADDR_DIVISOR: rdata <= divisor_reg;
          ADDR_STATUS: rdata <= {4'h0, status_reg};
          ADDR_ENABLE: rdata <= {4'h0, enable_reg};
          ADDR_TXDATA: rdata <= tx_shift_reg;
          ADDR_RXDATA: rdata <= rx_data_reg;
          default: rdata <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  normal_bit_a: assert property (@(posedge clk) disable iff (rst) // see [R1]
    !card_mode |-> (s_count == S_NORMAL && !gsm_mode && !block_mode))
    else $error("normal mode must ignore card fields");

  clock_select_a: assert property (@(posedge clk) disable iff (rst) // see [R2]
    (format_reg[1:0] == 2'b10) |-> (pre_shift == 3'h4))
    else $error("clock select 10 must divide by 16");

  clock_undiv_a: assert property (@(posedge clk) disable iff (rst) // see [R2]
    (format_reg[1:0] == 2'b00 && divisor_reg == 8'h00 && ce) |-> btick)
    else $error("clock select 00 must not divide");

  gsm_end_a: assert property (@(posedge clk) disable iff (rst) // see [R3]
    (tx_done && gsm_mode) |-> (tx_etu_reg == 4'ha && tx_sub_reg == s_count - 9'h001))
    else $error("gsm end flag not at 11.0 bit times");

  end_flag_a: assert property (@(posedge clk) disable iff (rst) // see [R3]
    (tx_done && ce) |=> status_reg[ST_TX_END])
    else $error("transmit end flag not set");

  clock_stop_a: assert property (@(posedge clk) disable iff (rst) // see [R4]
    (clk_stop && !card_clk && card_mode) |=> !card_clk)
    else $error("card clock ran while stopped");

  block_no_err_a: assert property (@(posedge clk) disable iff (rst) // see [R5]
    (block_mode && rx_done && ce && rx_par_bad) |=> (rx_state != RX_ERRSIG))
    else $error("error signal sent in block mode");

  parity_out_a: assert property (@(posedge clk) disable iff (rst) // see [R6]
    (tx_state == TX_SHIFT && tx_etu_reg == ETU_PARITY && !par_en) |-> tx_line)
    else $error("parity bit sent while disabled");

  parity_sense_a: assert property (@(posedge clk) disable iff (rst) // see [R8]
    (tx_state == TX_SHIFT && tx_etu_reg == ETU_PARITY && par_en)
      |-> (tx_line == ((^tx_shift_reg) ^ par_odd)))
    else $error("parity sense wrong");

  cycles_372_a: assert property (@(posedge clk) disable iff (rst) // see [R9]
    (card_mode && format_reg[3:2] == 2'b10) |-> (s_count == 9'h174))
    else $error("bit cycle code 10 must give 372");
endmodule
`default_nettype wire

// *** in_sync3.sv ***
`timescale 1ns/10ps
`default_nettype none
module in_sync3 #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic d,
  output logic q
);
  logic s1_reg, s2_reg, s3_reg;
  // the first stage feeds only the second; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= RESET_VAL;
      s2_reg <= RESET_VAL;
      s3_reg <= RESET_VAL;
      q <= RESET_VAL;
    end else if (ce) begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        q <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// *** serial_mode_smartcard_config_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_mode_smartcard_config_tb;
  import card_cfg_pkg::*;
  logic clk, rst, ce, wr, rd, send, bad_par, par_odd;
  logic [2:0] addr;
  logic [7:0] wdata, lfsr, fmt, div, send_byte;
  logic [15:0] bit_clks;
  logic [9:0] bits;
  wire logic [7:0] rdata;
  wire logic rxd, txd, card_clk, irq, busy, err_seen;
  int n_fail, tests_run, t, e, te, n;
  logic [7:0] case_fmt [6] = '{8'h02, 8'hfc, 8'ha2, 8'h34, 8'he8, 8'hbc};
  logic [5:0] case_card = 6'b111100;

  card_serial u_card_serial (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .txd(txd), .card_clk(card_clk), .irq(irq));
  card_model u_card_model (.clk(clk), .send(send), .send_byte(send_byte), .par_odd(par_odd),
    .bad_par(bad_par), .bit_clks(bit_clks), .txd(txd), .rxd(rxd), .busy(busy),
    .err_seen(err_seen));

  ////////////////////////////////////////
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [9:0] exp_frame(input logic [7:0] d, input logic pe, input logic odd);
    return {pe ? (^d ^ odd) : 1'b1, d, 1'b0};
  endfunction
  // clocks per bit time; only select codes 00 and 10 are exercised
  function automatic int exp_bit(input logic [7:0] f, input logic card, input logic [7:0] dv);
    int s;
    case (f[3:2])
      2'b00: s = 32;
      2'b01: s = 64;
      2'b10: s = 372;
      default: s = 256;
    endcase
    if (!card) s = 16;
    return s * ((int'(dv) + 1) << (f[1:0] == 2'b10 ? 4 : 0));
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] x);
    tests_run++;
    if (seen !== x) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, x);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] x);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    check(rdata, x);
    @(posedge clk);
  endtask
  // samples each bit mid-way, then times the end flag from the start bit
  task automatic tx_frame(input logic [7:0] d, input int tb, output logic [9:0] b, output int c);
    int k;
    wr_reg(ADDR_TXDATA, d);
    k = 0;
    while (txd !== 1'b0 && k < 100) begin
      @(negedge clk);
      k++;
    end
    for (int i = 0; i < 10; i++) begin
      repeat (i == 0 ? tb / 2 : tb) @(negedge clk);
      b[i] = txd;
    end
    c = tb / 2 + 9 * tb;
    while (irq !== 1'b1 && c < 20 * tb) begin
      @(negedge clk);
      c++;
    end
    @(posedge clk);
  endtask
  task automatic toggles(output int c);
    logic p;
    c = 0;
    repeat (4) @(posedge clk);
    p = card_clk;
    repeat (40) begin
      @(negedge clk);
      c += (card_clk !== p);
      p = card_clk;
    end
    @(posedge clk);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {wr, rd, send, bad_par, par_odd} = 5'h00;
    addr = 3'h0;
    wdata = 8'h00;
    send_byte = 8'h00;
    bit_clks = 16'h0020;
    lfsr = 8'h0d;
    n_fail = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 8; a++) if (a != 4) rchk(3'(a), 8'h00);
    lfsr = lfsr_next(lfsr);
    wr_reg(ADDR_FORMAT, lfsr);
    rchk(ADDR_FORMAT, lfsr);
    wr_reg(ADDR_MODE, 8'hff);
    rchk(ADDR_MODE, 8'h03);
    wr_reg(ADDR_ENABLE, 8'hff);
    rchk(ADDR_ENABLE, 8'h0f);
    wr_reg(ADDR_STATUS, 8'hff);
    rchk(ADDR_STATUS, 8'h00);
    wr_reg(ADDR_RXDATA, 8'h5a);
    rchk(ADDR_RXDATA, 8'h00);
    // card clock: stop control acts only with gsm timing
    wr_reg(ADDR_DIVISOR, 8'h01);
    for (int g = 0; g < 2; g++) begin
      wr_reg(ADDR_FORMAT, g == 1 ? 8'ha0 : 8'h20);
      toggles(n);
      check(g == 1 ? (n == 0 && card_clk === 1'b0) : (n >= 18 && n <= 22), 1);
    end
    wr_reg(ADDR_MODE, 8'h00);
    toggles(n);
    check(n == 0 && card_clk === 1'b0, 1);
    for (int c = 0; c < 6; c++) begin
      fmt = case_fmt[c];
      lfsr = lfsr_next(lfsr);
      div = {7'h00, lfsr[7]};
      wr_reg(ADDR_MODE, {7'h00, case_card[c]});
      wr_reg(ADDR_FORMAT, fmt);
      wr_reg(ADDR_DIVISOR, div);
      wr_reg(ADDR_ENABLE, 8'h01);
      t = exp_bit(fmt, case_card[c], div);
      tx_frame(lfsr, t, bits, e);
      check(bits, exp_frame(lfsr, fmt[5], fmt[4]));
      te = (case_card[c] && fmt[7]) ? 11 * t : 12 * t;
      // the basic tick runs free, so the start bit may be up to one tick short
      check(e >= te - t / 16 - 1 && e <= te + 1, 1);
      rchk(ADDR_STATUS, 8'h01);
      rchk(ADDR_TXDATA, lfsr);
      wr_reg(ADDR_ENABLE, 8'h00);
      check(irq, 1'b0);
      wr_reg(ADDR_CLEAR, 8'h01);
      rchk(ADDR_STATUS, 8'h00);
    end
    // receive from the card: good parity, bad parity, and bad parity in block mode
    wr_reg(ADDR_MODE, 8'h01);
    wr_reg(ADDR_DIVISOR, 8'h00);
    // a write while the clock enable is low must leave no trace
    ce <= 1'b0;
    wr_reg(ADDR_DIVISOR, 8'h33);
    ce <= 1'b1;
    rchk(ADDR_DIVISOR, 8'h00);
    wr_reg(ADDR_ENABLE, 8'h06);
    for (int i = 0; i < 4; i++) begin
      fmt = (i == 3 ? 8'h60 : 8'h20) | (i % 2 == 1 ? 8'h10 : 8'h00);
      wr_reg(ADDR_FORMAT, fmt);
      lfsr = lfsr_next(lfsr);
      bit_clks <= 16'(exp_bit(fmt, 1'b1, 8'h00));
      par_odd <= fmt[4];
      bad_par <= (i != 0);
      send_byte <= lfsr;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
      n = 0;
      while (busy === 1'b1 && n < 20000) begin
        @(posedge clk);
        n++;
      end
      check(irq, 1'b1);
      check(err_seen, i == 1 || i == 2);
      // the full flag left standing after frame 1 makes frame 2 an overrun
      rchk(ADDR_STATUS, i == 0 ? 8'h02 : (i == 2 ? 8'h0e : 8'h06));
      if (i == 0) rchk(ADDR_RXDATA, lfsr);
      wr_reg(ADDR_CLEAR, i == 1 ? 8'h0d : 8'h0f);
    end
    summarize();
  end
endmodule
`default_nettype wire

// *** tick_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [2:0] shift,
  input wire logic [7:0] divisor,
  output logic tick
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] last;
  // the longest period, 256 << 7 clocks, needs 15 counter bits
  if (CNT_W < 15) begin : g_width_check
    $error("tick_divider needs CNT_W of at least 15");
  end
  // period is (divisor + 1) << shift input clocks
  assign last = CNT_W'((({7'h00, divisor} + 15'h0001) << shift) - 15'h0001);
  assign tick = ce && (cnt_reg >= last);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= tick ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire
